// ### acb_pkg.sv
/*
  package for the control byte decoder: field positions, mode codes, reset values.
  assumes a single system clock domain; serial pins are synchronised in the decoder.
*/
package acb_pkg;
  localparam int ACB_BYTE_W = 8;
  localparam int ACB_START_BIT = 7;
  localparam int ACB_SEL_HI_BIT = 6;
  localparam int ACB_SEL_LO_BIT = 4;
  localparam int ACB_POL_BIT = 3;
  localparam int ACB_CFG_BIT = 2;
  localparam int ACB_MODE_HI_BIT = 1;
  localparam int ACB_MODE_LO_BIT = 0;
  localparam logic [2:0] ACB_CHAN_RST = 3'h0;
  localparam logic ACB_POL_RST = 1'h1;
  localparam logic ACB_CFG_RST = 1'h1;
  localparam logic [3:0] ACB_CNT_LAST = 4'h7;
  localparam logic ACB_CS_N_RST = 1'h1;
  localparam logic ACB_SCLK_RST = 1'h0;
  localparam logic ACB_DIN_RST = 1'h0;
  typedef enum logic [1:0] {
    ACB_MODE_FULL_PD = 2'b00,
    ACB_MODE_FAST_PD = 2'b01,
    ACB_MODE_INT_CLK = 2'b10,
    ACB_MODE_EXT_CLK = 2'b11
  } acb_mode_type;
  localparam acb_mode_type ACB_MODE_RST = ACB_MODE_FULL_PD;
endpackage

// ### acb_decoder.sv
/*
  serial control byte decoder: hunts for a start bit, shifts the seven bits after it, latches fields.
  assumes chip select, serial clock and data come from pins (asynchronous) and the
  serial clock is well below clk_sys / 4 so every edge is seen after synchronising.
  a byte cut short by chip select rising is dropped; the fields keep the last full byte.
*/
// Summary of operation
// - first one after chip select falls is the byte's most significant bit
// - bits six to four pick one of eight channels; host supplies the code
// - bit three: one unipolar, zero bipolar
// - bits one, zero: full power-down, fast power-down, internal or external clock
// - input configuration bit one means single-ended, zero differential
// - leading zeros before the start bit are ignored while chip select low
// - results are straight binary if unipolar, twos complement if bipolar
`timescale 1ns/1ps
module acb_decoder (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic [2:0] chan_sel,
  output logic chan_sel_hi,
  output logic chan_sel_mid,
  output logic chan_sel_lo,
  output logic polarity_select,
  output logic input_config_select,
  output logic mode_select_hi,
  output logic mode_select_lo,
  output acb_pkg::acb_mode_type mode,
  output logic result_twos_comp,
  output logic byte_valid
);
  import acb_pkg::*;

  typedef enum logic [0:0] {
    ACB_ST_HUNT = 1'b0,
    ACB_ST_SHIFT = 1'b1
  } acb_state_type;

  // pins cross into clk_sys here; decoding reads only the second flop of each
  logic cs_n_s;
  logic sclk_s;
  logic din_s;

  acb_sync #(
    .RESET_LEVEL(ACB_CS_N_RST)
  ) u_sync_cs (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_async(cs_n),
    .pin_sync(cs_n_s)
  );

  acb_sync #(
    .RESET_LEVEL(ACB_SCLK_RST)
  ) u_sync_sclk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_async(sclk),
    .pin_sync(sclk_s)
  );

  acb_sync #(
    .RESET_LEVEL(ACB_DIN_RST)
  ) u_sync_din (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_async(sdin),
    .pin_sync(din_s)
  );

  // edge detect resets to the idle-low pin level, so reset makes no false edge
  logic sclk_prev_r, sclk_prev_nxt;
  logic sclk_rise;

  always_comb begin
    sclk_prev_nxt = sclk_s;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_prev_r <= ACB_SCLK_RST;
    end else begin
      sclk_prev_r <= sclk_prev_nxt;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_r;

  acb_state_type state_r, state_nxt;
  logic [ACB_BYTE_W-2:0] shift_r, shift_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic pol_r, pol_nxt;
  logic cfg_r, cfg_nxt;
  acb_mode_type mode_r, mode_nxt;
  logic valid_r, valid_nxt;
  logic twos_r, twos_nxt;
  logic [ACB_BYTE_W-1:0] full_byte;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    chan_nxt = chan_r;
    pol_nxt = pol_r;
    cfg_nxt = cfg_r;
    mode_nxt = mode_r;
    valid_nxt = 1'b0;
    full_byte = {1'b1, shift_r};
    if (cs_n_s) begin
      // chip select high aborts a partial byte; no data clocked in
      state_nxt = ACB_ST_HUNT;
      cnt_nxt = 4'h0;
    end else if (sclk_rise) begin
      unique case (state_r)
        ACB_ST_HUNT: begin
          if (din_s) begin
            state_nxt = ACB_ST_SHIFT;
            cnt_nxt = 4'h1;
            shift_nxt = '0;
          end
        end
        ACB_ST_SHIFT: begin
          shift_nxt = {shift_r[ACB_BYTE_W-3:0], din_s};
          full_byte = {1'b1, shift_nxt};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == ACB_CNT_LAST) begin
            chan_nxt = full_byte[ACB_SEL_HI_BIT:ACB_SEL_LO_BIT];
            pol_nxt = full_byte[ACB_POL_BIT];
            cfg_nxt = full_byte[ACB_CFG_BIT];
            mode_nxt = acb_mode_type'(full_byte[ACB_MODE_HI_BIT:ACB_MODE_LO_BIT]);
            // one-cycle pulse; the fields then stand until the next full byte
            valid_nxt = 1'b1;
            state_nxt = ACB_ST_HUNT;
            cnt_nxt = 4'h0;
          end
        end
      endcase
    end
    twos_nxt = ~pol_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ACB_ST_HUNT;
      shift_r <= '0;
      cnt_r <= 4'h0;
      chan_r <= ACB_CHAN_RST;
      pol_r <= ACB_POL_RST;
      cfg_r <= ACB_CFG_RST;
      mode_r <= ACB_MODE_RST;
      valid_r <= 1'b0;
      twos_r <= ~ACB_POL_RST;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      chan_r <= chan_nxt;
      pol_r <= pol_nxt;
      cfg_r <= cfg_nxt;
      mode_r <= mode_nxt;
      valid_r <= valid_nxt;
      twos_r <= twos_nxt;
    end
  end

  assign chan_sel = chan_r;
  assign chan_sel_hi = chan_r[2];
  assign chan_sel_mid = chan_r[1];
  assign chan_sel_lo = chan_r[0];
  assign polarity_select = pol_r;
  assign input_config_select = cfg_r;
  assign mode_select_hi = mode_r[1];
  assign mode_select_lo = mode_r[0];
  assign mode = mode_r;
  assign result_twos_comp = twos_r;
  assign byte_valid = valid_r;
endmodule

// two-flop synchroniser for one pin; the reset level is the pin's idle level
module acb_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin_async,
  output logic pin_sync
);
  import acb_pkg::*;

  logic stage1_r, stage1_nxt;
  logic stage2_r, stage2_nxt;

  // stage one feeds stage two only: it may still be settling
  always_comb begin
    stage1_nxt = pin_async;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1_r <= RESET_LEVEL;
      stage2_r <= RESET_LEVEL;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign pin_sync = stage2_r;
endmodule

// ### acb_sva.sv
/* assertions on the control byte decoder ports.
   assumes each serial clock phase lasts at least four clk_sys cycles. */
`timescale 1ns/1ps
module acb_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [2:0] chan_sel,
  input wire logic chan_sel_hi,
  input wire logic chan_sel_mid,
  input wire logic chan_sel_lo,
  input wire logic polarity_select,
  input wire logic input_config_select,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire acb_pkg::acb_mode_type mode,
  input wire logic result_twos_comp,
  input wire logic byte_valid
);
  import acb_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_valid_pulse: assert property (
    byte_valid |=> !byte_valid) else $error("valid pulse too long");
  a_valid_in_frame: assert property (
    byte_valid |-> !$past(cs_n, 3)) else $error("byte taken outside a frame");
  a_valid_on_rise: assert property (
    byte_valid |-> sclk && $past(sclk, 2)) else $error("byte not ended by a rise");
  a_fields_hold: assert property (
    !byte_valid |-> $stable({chan_sel, polarity_select, input_config_select, mode}))
    else $error("fields moved without a byte");
  a_chan_bits: assert property (
    chan_sel == {chan_sel_hi, chan_sel_mid, chan_sel_lo}) else $error("channel bits differ");
  a_mode_code: assert property (
    mode == {mode_select_hi, mode_select_lo}) else $error("mode bits differ");
  a_result_format: assert property (
    result_twos_comp == !polarity_select) else $error("result format wrong");
  a_reset_fields: assert property (
    $fell(sys_rst) |-> chan_sel == ACB_CHAN_RST && polarity_select == ACB_POL_RST
    && input_config_select == ACB_CFG_RST && mode == ACB_MODE_RST) else $error("reset fields");
  cover property (byte_valid && mode == ACB_MODE_EXT_CLK);
  cover property (byte_valid && !polarity_select);
  cover property ($fell(cs_n));
endmodule
bind acb_decoder acb_checker u_chk (.*);

// ### acb_host.sv
/* host model: serial master shifting one control byte.
   assumes a 125 MHz clk_sys; each sclk phase lasts 6 cycles. */
`timescale 1ns/1ps
module acb_host (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sclk,
  output logic sdin
);
  initial {cs_n, sclk, sdin} = 3'b101;
  task automatic send(input logic [7:0] b, input int n);
    logic [9:0] v;
    v = {2'b00, b};
    cs_n <= 1'b0;
    for (int i = 9; i > 7 - n; i--) begin
      sdin <= v[i];
      repeat (6) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    cs_n <= 1'b1;
    // no pull on the line, so show the inverse
    sdin <= ~sdin;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// ### tb_top.sv
/* bench for the control byte decoder: byte table, then abort and reset cases.
   assumes the host model drives all serial pins. */
`timescale 1ns/1ps
module tb_top;
  import acb_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, cs_n, sclk, sdin, h, m, l, p, c, mh, ml, tc, bv;
  logic [2:0] ch;
  acb_mode_type md;
  int errors = 0, check_count = 0, cyc = 0, pulses = 0;
  // each row: control byte sent, then the 13 output bits it must leave standing
  logic [20:0] rows [8] = '{{8'h80, 13'h0001}, {8'h9d, 13'h04ea}, {8'ha6, 13'h0935},
    {8'hbb, 13'h0dde}, {8'hc8, 13'h1240}, {8'hd5, 13'h16ab}, {8'he2, 13'h1b15},
    {8'hff, 13'h1ffe}};
  wire [12:0] got = {ch, h, m, l, p, c, mh, ml, md, tc};
  always #4 clk_sys = ~clk_sys;
  acb_host u_host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdin(sdin));
  acb_decoder u_acb_decoder (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
    .sdin(sdin), .chan_sel(ch), .chan_sel_hi(h), .chan_sel_mid(m), .chan_sel_lo(l),
    .polarity_select(p), .input_config_select(c), .mode_select_hi(mh), .mode_select_lo(ml),
    .mode(md), .result_twos_comp(tc), .byte_valid(bv));
  // every full byte must give exactly one valid pulse, a cut one none
  always @(posedge clk_sys) if (bv === 1'b1) pulses++;
  task automatic chk_n(input int e);
    check_count++;
    if (pulses != e) begin
      errors++;
      $display("CHECK FAILED t=%0t pulses %h exp %h", $time, pulses, e);
    end
  endtask
  task automatic chk(input logic [12:0] e);
    check_count++;
    if (got !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the roughly 1500 cycles the sequence needs
  always @(posedge clk_sys) if (++cyc == 3000) begin
    errors++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(13'h0060);
    foreach (rows[i]) begin
      u_host.send(rows[i][20:13], 8);
      chk(rows[i][12:0]);
      chk_n(i + 1);
    end
    // a cut frame leaves the fields alone and must not spoil the next byte
    u_host.send(8'h80, 5);
    chk(13'h1ffe);
    chk_n(8);
    u_host.send(8'h9d, 8);
    chk(13'h04ea);
    chk_n(9);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(13'h0060);
    u_host.send(8'hc8, 8);
    chk(13'h1240);
    chk_n(10);
    final_report;
  end
endmodule
